// ### bench/snf_host_model.sv
// host side serial controller model driving the feature link
`timescale 1ns/100ps
module snf_host_model (
  output logic      sck,   // link clock, idle low between frames
  output logic      cs_n,  // chip select
  output logic      si,    // serial data to the device
  input  wire logic so,    // serial data from the device
  input  wire logic so_oe  // device drive enable
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    // one clean deselect edge so the device frame state starts known
    #1 cs_n = 1'b1;
  end

  // opcode, one feature address byte, then data, msb first
  task automatic xfer(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] dat,
                      input int nbits, output logic [7:0] rd);
    logic [23:0] v;
    v = {op, adr, dat};
    rd = 8'h00;
    #3.3 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = v[23-i];
      #7.5 sck = 1'b1;
      // an undriven line must never pass as data
      if (i >= 16) rd = {rd[6:0], so_oe ? so : 1'bx};
      #7.5 sck = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the feature and block protect logic
`timescale 1ns/100ps
module tb;
  logic                        clk, reset, wp_n, op_refused, op_granted, ecc_enable;
  logic                        sck, cs_n, si, so, so_oe;
  logic [2:0]                  security_mode;
  logic [7:0]                  rd;
  snf_pkg::snf_array_req_type  array_req;
  snf_pkg::snf_array_stat_type array_stat;
  int                          miscompares, num_checks, m_blk, m_cfg, m_wel, m_pf, m_ef;
  int                          bl[7];
  logic [7:0]                  modes[4] = '{8'h10, 8'h40, 8'hD0, 8'hD2};

  snf_feature_protect #(.BLK_W(10)) uut (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n),
    .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .array_req(array_req),
    .array_stat(array_stat), .op_refused(op_refused), .op_granted(op_granted),
    .security_mode(security_mode), .ecc_enable(ecc_enable));
  snf_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  always #25 clk = ~clk;

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input int exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp[7:0]) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp[7:0], got);
    end
  endtask

  function automatic int stat();
    return {array_stat.cache_busy, array_stat.ecc, m_pf[0], m_ef[0], m_wel[0], array_stat.busy};
  endfunction

  function automatic int locked(int b);
    int c;
    c = (m_blk >> 3) & 15;
    if (c == 0) return 0;
    if (c > 10) return 1;
    return m_blk[2] ? b < (1 << (c - 1)) : b >= 1024 - (1 << (c - 1));
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] d);
    int frozen;
    frozen = m_cfg[5] || (!m_blk[1] && m_blk[7] && !wp_n);
    host.xfer(op, adr, d, op == snf_pkg::OP_SET_FEAT ? 24 : 8, rd);
    // spacing lets the core see each command and the snapshot catch up
    repeat (10) @(negedge clk);
    if (op == snf_pkg::OP_WR_EN) m_wel = 1;
    if (op == snf_pkg::OP_WR_DIS) m_wel = 0;
    if (op == snf_pkg::OP_RESET) m_cfg &= 'h3D;
    if (op != snf_pkg::OP_SET_FEAT) return;
    if (adr == snf_pkg::FA_BLK_PROT) m_blk = frozen ? (m_blk & 'hFC) | (d & 2) : d & 'hFE;
    if (adr == snf_pkg::FA_SEC_CFG) m_cfg = (d & 'hF2) | (m_cfg & 'h20);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    cmd(snf_pkg::OP_SET_FEAT, adr, d);
  endtask

  task automatic rdc(input logic [7:0] adr, input int exp);
    // the snapshot only moves on link edges: a short select first lets a second
    // pending register change reach the link before the data phase
    host.xfer(snf_pkg::OP_GET_FEAT, adr, 8'h00, 8, rd);
    repeat (6) @(negedge clk);
    host.xfer(snf_pkg::OP_GET_FEAT, adr, 8'h00, 24, rd);
    repeat (8) @(negedge clk);
    chk("feature read", exp, rd);
  endtask

  task automatic req(input int b, input logic er);
    int lk;
    lk = locked(b & 1023);
    array_req = '{1'b1, er, b[9:0]};
    @(negedge clk);
    array_req.valid = 1'b0;
    chk("request outcome", lk ? 2 : 1, {6'h0, op_refused, op_granted});
    m_pf = lk && !er;
    m_ef = lk && er;
    @(negedge clk);
    chk("outcome pulse end", 0, {6'h0, op_refused, op_granted});
  endtask

  task automatic pwr_reset();
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    m_blk = 'h7C;
    m_cfg = 0;
    m_wel = 0;
    m_pf = 0;
    m_ef = 0;
  endtask

  initial begin
    repeat (20000) @(negedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    wp_n = 1'b1;
    array_req = '0;
    array_stat = '0;
    void'($urandom(32'h4FE74FD2));
    pwr_reset();
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    rdc(snf_pkg::FA_SEC_CFG, 0);
    array_stat = 5'($urandom);
    rdc(snf_pkg::FA_OP_STAT, stat());
    req(1023, 1'b0);
    req(0, 1'b1);
    rdc(snf_pkg::FA_OP_STAT, stat());
    wr(snf_pkg::FA_OP_STAT, 8'hFF);
    rdc(snf_pkg::FA_OP_STAT, stat());
    cmd(snf_pkg::OP_WR_EN, 8'h00, 8'h00);
    rdc(snf_pkg::FA_OP_STAT, stat());
    cmd(snf_pkg::OP_WR_DIS, 8'h00, 8'h00);
    rdc(snf_pkg::FA_OP_STAT, stat());
    wr(snf_pkg::FA_BLK_PROT, 8'h00);
    req(1023, 1'b0);
    wr(snf_pkg::FA_BLK_PROT, 8'h01);
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    wr(snf_pkg::FA_SEC_CFG, 8'h0D);
    rdc(snf_pkg::FA_SEC_CFG, m_cfg);
    cmd(8'hAB, 8'h00, 8'h00);
    rdc(8'hD0, 0);
    for (int t = 0; t < 32; t++) begin
      wr(snf_pkg::FA_BLK_PROT, 8'(t << 2 | ($urandom & 2)));
      rdc(snf_pkg::FA_BLK_PROT, m_blk);
      bl[2] = 1 << ((t >> 1) ? (t >> 1) - 1 : 0);
      bl = '{0, 1023, bl[2], bl[2] - 1, 1024 - bl[2], 1023 - bl[2], $urandom % 1024};
      foreach (bl[i]) req(bl[i], 1'($urandom));
    end
    wr(snf_pkg::FA_BLK_PROT, 8'hA8);
    wp_n = 1'b0;
    wr(snf_pkg::FA_BLK_PROT, 8'h02);
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    wr(snf_pkg::FA_BLK_PROT, 8'h00);
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    wp_n = 1'b1;
    wr(snf_pkg::FA_BLK_PROT, 8'h4C);
    foreach (modes[i]) begin
      wr(snf_pkg::FA_SEC_CFG, modes[i]);
      chk("mode", (m_cfg >> 5) & 6 | (m_cfg >> 1) & 1, {5'h0, security_mode});
      chk("ecc enable", m_cfg[4], {7'h0, ecc_enable});
    end
    cmd(snf_pkg::OP_RESET, 8'h00, 8'h00);
    chk("mode", 0, {5'h0, security_mode});
    rdc(snf_pkg::FA_SEC_CFG, m_cfg);
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    wr(snf_pkg::FA_SEC_CFG, 8'h20);
    wr(snf_pkg::FA_BLK_PROT, 8'h7C);
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    wr(snf_pkg::FA_SEC_CFG, 8'h00);
    rdc(snf_pkg::FA_SEC_CFG, m_cfg);
    pwr_reset();
    rdc(snf_pkg::FA_BLK_PROT, m_blk);
    rdc(snf_pkg::FA_SEC_CFG, m_cfg);
    give_verdict();
  end
endmodule

// ### core/snf_feature_protect.sv
// feature registers and volatile block protection behind the serial link
`timescale 1ns/100ps
// Functional notes
// - 0Fh reads and 1Fh writes a feature chosen by one address byte
// - written features hold until rewritten or power is cycled
// - reset command leaves feature settings alone unless noted
// - reset command returns security mode bits to 000
// - block lock at A0h: freeze, range code, top/bottom, pin disable
// - config at B0h: mode bits 7,6,1, lock tight 5, correction enable 4
// - status at C0h: cache busy, correction, fails, write latch, busy
// - write latch set only by write-enable command, not feature write
// - pin disable 0, freeze 1, pin low: block lock bits 7..2 ignored
// - power-up sets range code and top/bottom to ones, all locked
// - reset command keeps range code and top/bottom
// - program or erase to locked block sets its fail bit, refused
// - top/bottom 0: codes 1..10 lock highest 1 doubling to 512 blocks
// - top/bottom 1: codes 1..10 lock lowest blocks; 11 and up lock all
// - pin disable 1 stops write protect pin gating
// - power-up clears freeze and pin disable bits
// - lock tight freezes code, top/bottom, freeze until power cycle
// - modes: 000 normal, 010 otp pages, 110 otp protect, 111 perm lock off
// - feature write to status address changes no status bit
module snf_feature_protect #(
  parameter int BLK_W = 10
) (
  input  wire logic                        clk,          // core clock
  input  wire logic                        reset,        // power-on reset
  input  wire logic                        sck,          // serial link clock
  input  wire logic                        cs_n,         // chip select pin
  input  wire logic                        si,           // serial data in
  output logic                             so,           // serial data out
  output logic                             so_oe,        // data out drive enable
  input  wire logic                        wp_n,         // write protect pin
  input  wire snf_pkg::snf_array_req_type  array_req,    // program/erase request
  input  wire snf_pkg::snf_array_stat_type array_stat,   // array engine status
  output logic                             op_refused,   // request hit locked block
  output logic                             op_granted,   // request may proceed
  output logic [2:0]                       security_mode, // decoded mode bits
  output logic                             ecc_enable    // correction enable
);
  typedef struct packed {
    logic [7:0]  blk;
    logic [7:0]  cfg;
    logic        p_fail;
    logic        e_fail;
    logic        write_latch_flag;
    logic        wp_s1;
    logic        wp_s2;
    logic        evt_s1;
    logic        evt_s2;
    logic        evt_seen;
    logic        ack_s1;
    logic        ack_s2;
    logic        snap_req;
    logic [23:0] snap_bus;
    logic        rst_link;
    logic        refused;
    logic        granted;
    logic [2:0]  mode;
  } snf_core_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] adr;
    logic       more;
  } snf_frame_type;

  typedef struct packed {
    logic                 evt_tgl;
    snf_pkg::snf_evt_type evt;
    logic                 req_s1;
    logic                 req_s2;
    logic                 ack_tgl;
    logic [23:0]          snap;
  } snf_xfer_type;

  snf_core_type  c_q, c_d;
  snf_frame_type f_q, f_d;
  snf_xfer_type  x_q, x_d;
  logic          so_q, oe_q;
  logic [7:0]    rx_byte, rd_byte, status;
  logic          evt_new, wp_gate, req_locked;

  // range decode: code 0 locks nothing, 1..BLK_W lock a power of two, others lock all
  function automatic logic blk_locked(input logic [7:0] b, input logic [BLK_W-1:0] n);
    logic [3:0]     code;
    logic [BLK_W:0] span;
    logic [BLK_W:0] full;
    code = b[snf_pkg::BP_CODE_HI:snf_pkg::BP_CODE_LO];
    full = (BLK_W+1)'(1) << BLK_W;
    span = (BLK_W+1)'(1) << (code - 4'h1);
    if (code == 4'h0) begin
      blk_locked = 1'b0;
    end else if (code > 4'(BLK_W)) begin
      blk_locked = 1'b1;
    end else if (b[snf_pkg::BP_TB]) begin
      blk_locked = {1'b0, n} < span;
    end else begin
      blk_locked = {1'b0, n} >= (full - span);
    end
  endfunction

  // ---------------- link side, serial clock ----------------
  assign rx_byte = {f_q.sh[6:0], si};

  always_comb begin
    f_d = f_q;
    f_d.sh = rx_byte;
    f_d.cnt = (f_q.cnt == snf_pkg::CNT_WRAP) ? snf_pkg::CNT_DATA0 : f_q.cnt + 5'h01;
    // the count wraps inside the data phase, so remember that the first data byte is gone
    if (f_q.cnt == snf_pkg::CNT_WRAP) begin
      f_d.more = 1'b1;
    end
    if (f_q.cnt == snf_pkg::CNT_OP_LAST) begin
      f_d.op = rx_byte;
    end
    if (f_q.cnt == snf_pkg::CNT_ADR_LAST) begin
      f_d.adr = rx_byte;
    end
  end

  // frame state restarts with every select
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_comb begin
    x_d = x_q;
    x_d.req_s1 = c_q.snap_req;
    x_d.req_s2 = x_q.req_s1;
    // snapshot bus is held still by the core until this ack returns
    if (x_q.req_s2 != x_q.ack_tgl) begin
      x_d.snap = c_q.snap_bus;
      x_d.ack_tgl = x_q.req_s2;
    end
    if (!cs_n && f_q.cnt == snf_pkg::CNT_OP_LAST &&
        (rx_byte == snf_pkg::OP_WR_EN || rx_byte == snf_pkg::OP_WR_DIS ||
         rx_byte == snf_pkg::OP_RESET)) begin
      x_d.evt = '{op: rx_byte, adr: 8'h00, data: 8'h00};
      x_d.evt_tgl = ~x_q.evt_tgl;
    end
    // one address byte then one data byte
    if (!cs_n && !f_q.more && f_q.cnt == snf_pkg::CNT_DATA_LAST &&
        f_q.op == snf_pkg::OP_SET_FEAT) begin
      x_d.evt = '{op: f_q.op, adr: f_q.adr, data: rx_byte};
      x_d.evt_tgl = ~x_q.evt_tgl;
    end
  end

  // reset comes from a core flop, so it is glitch free
  always_ff @(posedge sck or posedge c_q.rst_link) begin
    if (c_q.rst_link) begin
      x_q <= '0;
    end else begin
      x_q <= x_d;
    end
  end

  always_comb begin
    unique case (f_q.adr)
      snf_pkg::FA_BLK_PROT: rd_byte = x_q.snap[23:16];
      snf_pkg::FA_SEC_CFG:  rd_byte = x_q.snap[15:8];
      snf_pkg::FA_OP_STAT:  rd_byte = x_q.snap[7:0];
      default:              rd_byte = 8'h00;
    endcase
  end

  // data leaves on the falling edge so the host samples it on the rising one
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (f_q.op == snf_pkg::OP_GET_FEAT && f_q.cnt >= snf_pkg::CNT_DATA0) begin
      so_q <= rd_byte[3'h7 - f_q.cnt[2:0]];
      oe_q <= 1'b1;
    end else begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end
  end

  assign so = so_q;
  assign so_oe = oe_q;

  // ---------------- core side, clk ----------------
  assign evt_new = c_q.evt_s2 != c_q.evt_seen;
  // pin gating only while pin disable is clear
  assign wp_gate = !c_q.blk[snf_pkg::BP_PIN_DIS] && c_q.blk[snf_pkg::BP_FREEZE] && !c_q.wp_s2;
  assign req_locked = blk_locked(c_q.blk, array_req.block[BLK_W-1:0]);
  assign status = {array_stat.cache_busy, array_stat.ecc, c_q.p_fail, c_q.e_fail,
                   c_q.write_latch_flag, array_stat.busy};

  always_comb begin
    c_d = c_q;
    c_d.wp_s1 = wp_n;
    c_d.wp_s2 = c_q.wp_s1;
    c_d.evt_s1 = x_q.evt_tgl;
    c_d.evt_s2 = c_q.evt_s1;
    c_d.evt_seen = c_q.evt_s2;
    c_d.ack_s1 = x_q.ack_tgl;
    c_d.ack_s2 = c_q.ack_s1;
    c_d.rst_link = 1'b0;
    c_d.refused = 1'b0;
    c_d.granted = 1'b0;
    if (array_req.valid) begin
      if (req_locked) begin
        c_d.refused = 1'b1;
        c_d.p_fail = !array_req.erase;
        c_d.e_fail = array_req.erase;
      end else begin
        c_d.granted = 1'b1;
        c_d.p_fail = 1'b0;
        c_d.e_fail = 1'b0;
      end
    end
    if (evt_new) begin
      unique case (x_q.evt.op)
        snf_pkg::OP_WR_EN:  c_d.write_latch_flag = 1'b1;
        snf_pkg::OP_WR_DIS: c_d.write_latch_flag = 1'b0;
        // reset command only clears the mode bits
        snf_pkg::OP_RESET:  c_d.cfg = c_q.cfg & ~snf_pkg::CFG_MODE_MASK;
        snf_pkg::OP_SET_FEAT: begin
          unique case (x_q.evt.adr)
            snf_pkg::FA_BLK_PROT: begin
              c_d.blk = x_q.evt.data & 8'hFE;
              if (wp_gate || c_q.cfg[snf_pkg::CF_LOCK_TIGHT]) begin
                c_d.blk = (c_q.blk & snf_pkg::BLK_FROZEN_MASK) |
                          (x_q.evt.data & 8'h02);
              end
            end
            snf_pkg::FA_SEC_CFG: begin
              c_d.cfg = x_q.evt.data & snf_pkg::CFG_USED_MASK;
              c_d.cfg[snf_pkg::CF_LOCK_TIGHT] = c_q.cfg[snf_pkg::CF_LOCK_TIGHT] |
                                               x_q.evt.data[snf_pkg::CF_LOCK_TIGHT];
            end
            default: c_d.cfg = c_q.cfg;
          endcase
        end
        default: c_d.write_latch_flag = c_q.write_latch_flag;
      endcase
    end
    // mode decode from the three select bits
    c_d.mode = {c_d.cfg[snf_pkg::CF_MODE2], c_d.cfg[snf_pkg::CF_MODE1],
                c_d.cfg[snf_pkg::CF_MODE0]};
    // publish a fresh snapshot only when the previous one was taken
    if (c_q.ack_s2 == c_q.snap_req && c_q.snap_bus != {c_q.blk, c_q.cfg, status}) begin
      c_d.snap_bus = {c_q.blk, c_q.cfg, status};
      c_d.snap_req = ~c_q.snap_req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      c_q <= '0;
      c_q.blk <= snf_pkg::BLK_RESET;
      c_q.cfg <= snf_pkg::CFG_RESET;
      c_q.rst_link <= 1'b1;
      c_q.wp_s1 <= 1'b1;
      c_q.wp_s2 <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign op_refused = c_q.refused;
  assign op_granted = c_q.granted;
  assign security_mode = c_q.mode;
  assign ecc_enable = c_q.cfg[snf_pkg::CF_ECC_EN];

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_powerup_locked: assert property ($past(reset) |-> c_q.blk == snf_pkg::BLK_RESET)
    else $error("block lock not at power-up value");
  a_freeze_gate: assert property (evt_new && x_q.evt.op == snf_pkg::OP_SET_FEAT &&
    x_q.evt.adr == snf_pkg::FA_BLK_PROT && wp_gate |=>
    c_q.blk[7:2] == $past(c_q.blk[7:2]))
    else $error("frozen block lock bits changed");
  a_lock_tight_hold: assert property (c_q.cfg[snf_pkg::CF_LOCK_TIGHT] |=>
    c_q.cfg[snf_pkg::CF_LOCK_TIGHT] && ($past(c_q.blk[7:2]) == c_q.blk[7:2]))
    else $error("lock tight cleared or protection changed");
  a_reset_keeps_bp: assert property (evt_new && x_q.evt.op == snf_pkg::OP_RESET |=>
    $stable(c_q.blk) && c_q.mode == snf_pkg::SEC_NORMAL ##1
    security_mode == snf_pkg::SEC_NORMAL)
    else $error("reset command changed protection or kept mode");
  a_prog_refused: assert property (array_req.valid && !array_req.erase && req_locked |=>
    op_refused && c_q.p_fail && !c_q.e_fail && !op_granted)
    else $error("program to locked block not refused");
  a_erase_refused: assert property (array_req.valid && array_req.erase && req_locked |=>
    op_refused && c_q.e_fail && !c_q.p_fail)
    else $error("erase to locked block not refused");
  a_status_wr_ignored: assert property (evt_new && x_q.evt.op == snf_pkg::OP_SET_FEAT &&
    x_q.evt.adr == snf_pkg::FA_OP_STAT && !array_req.valid |=>
    $stable(c_q.write_latch_flag) && $stable(c_q.p_fail))
    else $error("status write changed status");
  a_wel_command: assert property (evt_new && x_q.evt.op == snf_pkg::OP_WR_EN |=> c_q.write_latch_flag)
    else $error("write enable did not set latch");
  a_unused_zero: assert property (c_q.blk[0] == 1'b0 && c_q.cfg[3:2] == 2'h0 &&
    c_q.cfg[0] == 1'b0)
    else $error("unused feature bit set");
endmodule

// ### core/snf_pkg.sv
// constants and types for the serial nand feature and block protect logic
package snf_pkg;
  localparam logic [7:0] OP_GET_FEAT  = 8'h0F;
  localparam logic [7:0] OP_SET_FEAT  = 8'h1F;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_RESET     = 8'hFF;
  localparam logic [7:0] FA_BLK_PROT  = 8'hA0;
  localparam logic [7:0] FA_SEC_CFG   = 8'hB0;
  localparam logic [7:0] FA_OP_STAT   = 8'hC0;
  // block_protection_control fields
  localparam int BP_FREEZE = 7;
  localparam int BP_CODE_HI = 6;
  localparam int BP_CODE_LO = 3;
  localparam int BP_TB     = 2;
  localparam int BP_PIN_DIS = 1;
  localparam logic [7:0] BLK_RESET = 8'h7C;
  localparam logic [7:0] BLK_FROZEN_MASK = 8'hFC;
  // security_and_correction_config fields
  localparam int CF_MODE2 = 7;
  localparam int CF_MODE1 = 6;
  localparam int CF_LOCK_TIGHT = 5;
  localparam int CF_ECC_EN = 4;
  localparam int CF_MODE0 = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_USED_MASK = 8'hF2;
  localparam logic [7:0] CFG_MODE_MASK = 8'hC2;
  // security modes, {mode2, mode1, mode0}
  localparam logic [2:0] SEC_NORMAL = 3'h0;
  localparam logic [2:0] SEC_OTP_PAGES = 3'h2;
  localparam logic [2:0] SEC_OTP_PROT = 3'h6;
  localparam logic [2:0] SEC_PERM_DIS = 3'h7;
  // frame bit counts on the link
  localparam logic [4:0] CNT_OP_LAST   = 5'h07;
  localparam logic [4:0] CNT_ADR_LAST  = 5'h0F;
  localparam logic [4:0] CNT_DATA0     = 5'h10;
  localparam logic [4:0] CNT_DATA_LAST = 5'h17;
  localparam logic [4:0] CNT_WRAP      = 5'h1F;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] adr;
    logic [7:0] data;
  } snf_evt_type;

  typedef struct packed {
    logic       valid;
    logic       erase;
    logic [9:0] block;
  } snf_array_req_type;

  typedef struct packed {
    logic       busy;
    logic       cache_busy;
    logic [2:0] ecc;
  } snf_array_stat_type;
endpackage
